// >>> src/hbs_pkg.sv
/*
 * hbs_pkg: constants, register map and state encoding for the hoist brake sequencer.
 * assumes a 100 MHz system clock; all times are programmed in 10 ms ticks.
 */
package hbs_pkg;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_MHZ = 100;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = CLK_MHZ * 1000 * TICK_MS;
    localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);
    // ****************************************************************
    // default times in 10 ms ticks
    // ****************************************************************
    localparam logic [15:0] START_INJ_RST = 16'h001E;
    localparam logic [15:0] STOP_INJ_RST = 16'h003C;
    localparam logic [15:0] BRAKE_OPEN_RST = 16'h0014;
    localparam logic [15:0] BRAKE_CLOSE_RST = 16'h000A;
    localparam logic [15:0] RUN_DELAY_RST = 16'h000A;
    localparam logic [15:0] CONT_OPEN_RST = 16'h000A;
    // ****************************************************************
    // function codes
    // ****************************************************************
    localparam logic [7:0] FN_BRAKE_RELEASE = 8'h28;
    localparam logic [7:0] FN_CONT_CLOSE = 8'h29;
    localparam logic [7:0] FN_NOMINAL = 8'h50;
    localparam logic [7:0] FN_INTERMED = 8'h51;
    localparam logic [7:0] FN_RELEVEL = 8'h52;
    localparam logic [7:0] FN_LEVELING = 8'h53;
    localparam logic [7:0] FN_CONT_CONFIRM = 8'h56;
    localparam logic [7:0] FN_SPEED_REF = 8'h00;
    localparam logic [7:0] FN_TORQUE_COMP = 8'h0E;
    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] REG_START_INJ = 8'h00;
    localparam logic [7:0] REG_STOP_INJ = 8'h04;
    localparam logic [7:0] REG_BRAKE_OPEN = 8'h08;
    localparam logic [7:0] REG_BRAKE_CLOSE = 8'h0C;
    localparam logic [7:0] REG_RUN_DELAY = 8'h10;
    localparam logic [7:0] REG_CONT_OPEN = 8'h14;
    localparam logic [7:0] REG_IN_SEL = 8'h18;
    localparam logic [7:0] REG_OUT_SEL = 8'h1C;
    localparam logic [7:0] REG_ANA_SEL = 8'h20;
    localparam logic [7:0] REG_SPEED = 8'h24;
    localparam logic [7:0] REG_STATUS = 8'h28;
    localparam logic [39:0] IN_SEL_RST = 40'h0053525150;
    localparam logic [23:0] OUT_SEL_RST = 24'h002928;
    localparam logic [23:0] ANA_SEL_RST = 24'h000000;
    localparam logic [15:0] SPD_NOM_RST = 16'h1000;
    localparam logic [15:0] SPD_LEV_RST = 16'h0100;
    localparam logic [15:0] ACC_STEP_RST = 16'h0001;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // ****************************************************************
    // sequence states
    // ****************************************************************
    typedef enum logic [9:0] {
        HBS_IDLE = 10'h001,
        HBS_CONT = 10'h002,
        HBS_RUNDLY = 10'h004,
        HBS_HOLD = 10'h008,
        HBS_ACCEL = 10'h010,
        HBS_LEVEL = 10'h020,
        HBS_DECEL = 10'h040,
        HBS_STOPINJ = 10'h080,
        HBS_OFF = 10'h100,
        HBS_OPEN = 10'h200
    } hbs_state_t;
endpackage

// >>> src/hbs_top.sv
/*
 * hbs_top: brake sequence without start torque compensation, AXI4-Lite register slave.
 * assumes the elevator controller drives direction, output block and digital inputs
 * asynchronously; all but mf_in[4], which is never read, pass a two-stage synchroniser.
 */
`timescale 1ns/1ps
module hbs_top
    import hbs_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic dir_fwd, // forward direction command
    input wire logic dir_rev, // reverse direction command
    input wire logic hw_block_n, // hardware output block, low prevents a start; not read from HBS_CONT through HBS_OFF
    input wire logic [4:0] mf_in, // multi-function digital inputs
    output logic [2:0] mf_out, // multi-function digital outputs
    output logic output_enable, // output stage enabled
    output logic zero_hold, // dc injection / zero servo active
    output logic [15:0] speed_out // speed reference to motor control
);
    typedef struct packed {
        hbs_state_t st;
        logic [19:0] pre;
        logic [15:0] tmr;
        logic [15:0] tmr2;
        logic [15:0] spd;
        logic brk, cont, oen, hold;
        logic [15:0] t_sinj, t_pinj, t_bo, t_bc, t_rd, t_co;
        logic [39:0] in_sel;
        logic [23:0] out_sel;
        logic [23:0] ana_sel;
        logic [15:0] spd_nom, spd_lev, acc;
        logic aw_got, w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [6:0] s1, s2;
        logic [2:0] mfo;
    } hbs_regs_t;
    hbs_regs_t q_r, q_nxt;
    // ****************************************************************
    // helpers
    // ****************************************************************
    // true when any of the five inputs that is set in v is programmed with the given code
    function automatic logic fn_in(input logic [39:0] sel, input logic [4:0] v,
                                   input logic [7:0] code);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (sel[i*8 +: 8] == code && v[i]) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction
    function automatic logic [15:0] step(input logic [15:0] cur, input logic [15:0] tgt,
                                         input logic [15:0] a);
        logic [15:0] r;
        r = tgt;
        if (cur < tgt && tgt - cur > a) begin
            r = cur + a;
        end else if (cur > tgt && cur - tgt > a) begin
            r = cur - a;
        end
        return r;
    endfunction
    // register word at a byte address; bit 32 is set when the address is mapped
    function automatic logic [32:0] reg_rd(input hbs_regs_t q, input logic [7:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h00000000};
        case (a)
            REG_START_INJ: r[31:0] = {16'h0000, q.t_sinj};
            REG_STOP_INJ: r[31:0] = {16'h0000, q.t_pinj};
            REG_BRAKE_OPEN: r[31:0] = {16'h0000, q.t_bo};
            REG_BRAKE_CLOSE: r[31:0] = {16'h0000, q.t_bc};
            REG_RUN_DELAY: r[31:0] = {16'h0000, q.t_rd};
            REG_CONT_OPEN: r[31:0] = {16'h0000, q.t_co};
            REG_IN_SEL: r[31:0] = q.in_sel[31:0];
            REG_OUT_SEL: r[31:0] = {8'h00, q.out_sel};
            REG_ANA_SEL: r[31:0] = {8'h00, q.ana_sel};
            REG_SPEED: r[31:0] = {q.spd_lev, q.spd_nom};
            REG_STATUS: r[31:0] = {6'h00, q.st, q.spd};
            default: r[32] = 1'b0;
        endcase
        return r;
    endfunction
    logic dir, blk_ok, confirm_cfg, confirm, lev, nom, itm, rel, ana_ok, tick;
    logic [15:0] sel_spd, tgt;
    logic [31:0] rd_val, wr_old, wr_new;
    logic wr_hit, rd_hit;
    always_comb begin
        q_nxt = q_r;
        // ****************************************************************
        // input synchronisers
        // ****************************************************************
        q_nxt.s1 = {dir_fwd, dir_rev, hw_block_n, mf_in[3:0]};
        q_nxt.s2 = q_r.s1;
        dir = q_r.s2[6] ^ q_r.s2[5];
        blk_ok = q_r.s2[4];
        // ****************************************************************
        // speed selection
        // ****************************************************************
        nom = fn_in(q_r.in_sel, {1'b0, q_r.s2[3:0]}, FN_NOMINAL);
        itm = fn_in(q_r.in_sel, {1'b0, q_r.s2[3:0]}, FN_INTERMED);
        rel = fn_in(q_r.in_sel, {1'b0, q_r.s2[3:0]}, FN_RELEVEL);
        lev = fn_in(q_r.in_sel, {1'b0, q_r.s2[3:0]}, FN_LEVELING);
        confirm_cfg = fn_in(q_r.in_sel, 5'h1F, FN_CONT_CONFIRM);
        confirm = fn_in(q_r.in_sel, {1'b0, q_r.s2[3:0]}, FN_CONT_CONFIRM);
        sel_spd = (nom | itm | rel) ? q_r.spd_nom : 16'h0000;
        ana_ok = q_r.ana_sel[7:0] == FN_SPEED_REF && q_r.ana_sel[15:8] != FN_TORQUE_COMP
                 && q_r.ana_sel[23:16] != FN_TORQUE_COMP;
        // ****************************************************************
        // timers
        // ****************************************************************
        tick = q_r.pre == TICK_LAST;
        q_nxt.pre = tick ? 20'h00000 : q_r.pre + 20'h00001;
        q_nxt.tmr = (tick && q_r.tmr != 16'h0000) ? q_r.tmr - 16'h0001 : q_r.tmr;
        q_nxt.tmr2 = (tick && q_r.tmr2 != 16'h0000) ? q_r.tmr2 - 16'h0001 : q_r.tmr2;
        tgt = lev ? q_r.spd_lev : sel_spd;
        // ****************************************************************
        // sequence
        // ****************************************************************
        case (q_r.st)
            HBS_IDLE: begin
                if (dir && blk_ok && (sel_spd != 16'h0000 || lev) && ana_ok) begin
                    q_nxt.cont = 1'b1;
                    q_nxt.tmr = q_r.t_rd;
                    q_nxt.pre = 20'h00000;
                    q_nxt.st = HBS_CONT;
                end
            end
            HBS_CONT: begin
                if (confirm_cfg ? confirm : q_r.tmr == 16'h0000) begin
                    q_nxt.tmr = q_r.t_rd;
                    q_nxt.st = HBS_RUNDLY;
                end
            end
            HBS_RUNDLY: begin
                if (q_r.tmr == 16'h0000 || !confirm_cfg) begin
                    q_nxt.oen = 1'b1;
                    q_nxt.hold = 1'b1;
                    q_nxt.tmr = q_r.t_bo;
                    q_nxt.tmr2 = q_r.t_sinj > q_r.t_bo ? q_r.t_sinj : q_r.t_bo;
                    q_nxt.st = HBS_HOLD;
                end
            end
            HBS_HOLD: begin
                if (q_r.tmr == 16'h0000) begin
                    q_nxt.brk = 1'b1;
                end
                if (q_r.tmr == 16'h0000 && q_r.tmr2 == 16'h0000) begin
                    q_nxt.hold = 1'b0;
                    q_nxt.st = HBS_ACCEL;
                end
            end
            HBS_ACCEL: begin
                q_nxt.spd = step(q_r.spd, tgt, q_r.acc);
                if (lev) begin
                    q_nxt.st = HBS_LEVEL;
                end
            end
            HBS_LEVEL: begin
                q_nxt.spd = step(q_r.spd, q_r.spd_lev, q_r.acc);
                if (!lev) begin
                    q_nxt.st = HBS_DECEL;
                end
            end
            HBS_DECEL: begin
                q_nxt.spd = step(q_r.spd, 16'h0000, q_r.acc);
                if (q_r.spd == 16'h0000) begin
                    q_nxt.hold = 1'b1;
                    q_nxt.tmr = q_r.t_bc;
                    q_nxt.tmr2 = q_r.t_pinj;
                    q_nxt.pre = 20'h00000;
                    q_nxt.st = HBS_STOPINJ;
                end
            end
            HBS_STOPINJ: begin
                if (q_r.tmr == 16'h0000) begin
                    q_nxt.brk = 1'b0;
                end
                if (q_r.tmr == 16'h0000 && q_r.tmr2 == 16'h0000) begin
                    q_nxt.oen = 1'b0;
                    q_nxt.hold = 1'b0;
                    q_nxt.tmr = q_r.t_co;
                    q_nxt.st = HBS_OFF;
                end
            end
            HBS_OFF: begin
                if (q_r.tmr == 16'h0000) begin
                    q_nxt.cont = 1'b0;
                    q_nxt.st = HBS_OPEN;
                end
            end
            HBS_OPEN: begin
                // wait for the controller to drop direction or block the output
                if (!dir || !blk_ok) begin
                    q_nxt.st = HBS_IDLE;
                end
            end
            default: begin
                q_nxt.st = HBS_IDLE;
            end
        endcase
        // ****************************************************************
        // multi-function outputs
        // ****************************************************************
        for (int i = 0; i < 3; i++) begin
            q_nxt.mfo[i] = (q_r.out_sel[i*8 +: 8] == FN_BRAKE_RELEASE && q_nxt.brk)
                || (q_r.out_sel[i*8 +: 8] == FN_CONT_CLOSE && q_nxt.cont);
        end
        // ****************************************************************
        // axi4-lite slave
        // ****************************************************************
        if (s_axi_awvalid && s_axi_awready) begin
            q_nxt.aw_got = 1'b1;
            q_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            q_nxt.w_got = 1'b1;
            q_nxt.wdata = s_axi_wdata;
            q_nxt.wstrb = s_axi_wstrb;
        end
        {wr_hit, wr_old} = reg_rd(q_r, q_r.awaddr);
        if (q_r.awaddr == REG_STATUS) begin
            wr_hit = 1'b0;
        end
        wr_new = wmerge(wr_old, q_r.wdata, q_r.wstrb);
        if (q_r.aw_got && q_r.w_got && !q_r.bvalid) begin
            q_nxt.aw_got = 1'b0;
            q_nxt.w_got = 1'b0;
            q_nxt.bvalid = 1'b1;
            q_nxt.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
            case (q_r.awaddr)
                REG_START_INJ: q_nxt.t_sinj = wr_new[15:0];
                REG_STOP_INJ: q_nxt.t_pinj = wr_new[15:0];
                REG_BRAKE_OPEN: q_nxt.t_bo = wr_new[15:0];
                REG_BRAKE_CLOSE: q_nxt.t_bc = wr_new[15:0];
                REG_RUN_DELAY: q_nxt.t_rd = wr_new[15:0];
                REG_CONT_OPEN: q_nxt.t_co = wr_new[15:0];
                REG_IN_SEL: q_nxt.in_sel[31:0] = wr_new;
                REG_OUT_SEL: q_nxt.out_sel = wr_new[23:0];
                REG_ANA_SEL: q_nxt.ana_sel = wr_new[23:0];
                REG_SPEED: {q_nxt.spd_lev, q_nxt.spd_nom} = wr_new;
                default: ;
            endcase
        end
        if (q_r.bvalid && s_axi_bready) begin
            q_nxt.bvalid = 1'b0;
        end
        {rd_hit, rd_val} = reg_rd(q_r, s_axi_araddr);
        if (s_axi_arvalid && s_axi_arready) begin
            q_nxt.rvalid = 1'b1;
            q_nxt.rdata = rd_val;
            q_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (q_r.rvalid && s_axi_rready) begin
            q_nxt.rvalid = 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_r <= '{st: HBS_IDLE, t_sinj: START_INJ_RST, t_pinj: STOP_INJ_RST,
                t_bo: BRAKE_OPEN_RST, t_bc: BRAKE_CLOSE_RST, t_rd: RUN_DELAY_RST,
                t_co: CONT_OPEN_RST, in_sel: IN_SEL_RST, out_sel: OUT_SEL_RST,
                ana_sel: ANA_SEL_RST, spd_nom: SPD_NOM_RST, spd_lev: SPD_LEV_RST,
                acc: ACC_STEP_RST, default: '0};
        end else begin
            q_r <= q_nxt;
        end
    end
    assign s_axi_awready = !q_r.aw_got;
    assign s_axi_wready = !q_r.w_got;
    assign s_axi_bvalid = q_r.bvalid;
    assign s_axi_bresp = q_r.bresp;
    assign s_axi_arready = !q_r.rvalid;
    assign s_axi_rvalid = q_r.rvalid;
    assign s_axi_rdata = q_r.rdata;
    assign s_axi_rresp = q_r.rresp;
    assign mf_out = q_r.mfo;
    assign output_enable = q_r.oen;
    assign zero_hold = q_r.hold;
    assign speed_out = q_r.spd;
endmodule

// >>> dv/hbs_chk_sva.sv
/* hbs_chk: port assertions for hbs_top.
   assumes default output selects: mf_out[0] brake, mf_out[1] contactor. */
`timescale 1ns/1ps
module hbs_chk (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, active low
    input wire logic dir_fwd, // forward command
    input wire logic dir_rev, // reverse command
    input wire logic hw_block_n, // output block, low blocks
    input wire logic [2:0] mf_out, // digital outputs
    input wire logic output_enable, // output stage on
    input wire logic zero_hold, // injection active
    input wire logic [15:0] speed_out // ramp speed
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence cont_up_s;
        $rose(mf_out[1]);
    endsequence
    sequence stop_s;
        $fell(output_enable);
    endsequence
    cont_cause_a: assert property (cont_up_s |->
        $past(hw_block_n) && ($past(dir_fwd) != $past(dir_rev))) else $error("contactor cause");
    oe_cont_a: assert property (output_enable |-> mf_out[1])
        else $error("output without contactor");
    brake_oe_a: assert property (mf_out[0] |-> output_enable)
        else $error("brake open without output");
    brake_still_a: assert property ($rose(mf_out[0]) |-> speed_out == 16'h0000)
        else $error("brake opened while moving");
    run_brake_a: assert property (speed_out != 16'h0000 |-> mf_out[0])
        else $error("moving with brake closed");
    hold_still_a: assert property (zero_hold |-> speed_out == 16'h0000)
        else $error("holding while moving");
    ramp_step_a: assert property (!$stable(speed_out) |->
        speed_out == 16'($past(speed_out) + 1) || speed_out == 16'($past(speed_out) - 1))
        else $error("speed jump");
    stop_order_a: assert property (stop_s |-> !mf_out[0] && speed_out == 16'h0000)
        else $error("output cut before brake closed");
    cont_drop_a: assert property ($fell(mf_out[1]) |-> !output_enable)
        else $error("contactor opened under output");
endmodule
bind hbs_top hbs_chk u_chk (.aclk(aclk), .aresetn(aresetn), .dir_fwd(dir_fwd),
    .dir_rev(dir_rev), .hw_block_n(hw_block_n), .mf_out(mf_out),
    .output_enable(output_enable), .zero_hold(zero_hold), .speed_out(speed_out));

// >>> dv/hbs_ctrl_model.sv
/* hbs_ctrl_model: elevator controller facing hbs_top.
   assumes mf_in[0] nominal, mf_in[2] confirm, mf_in[3] leveling. */
`timescale 1ns/1ps
module hbs_ctrl_model (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, active low
    input wire logic go, // start a ride
    input wire logic [1:0] spd, // bit0 nominal, bit1 leveling
    input wire logic cont_close, // contactor command
    input wire logic out_on, // output stage state
    output logic dir_fwd, // forward command
    output logic dir_rev, // reverse command
    output logic hw_block_n, // output block, low blocks
    output logic [4:0] mf_in // digital inputs
);
    logic run_r;
    logic oe_r;
    logic [2:0] ack_r;
    always_ff @(posedge aclk) begin
        oe_r <= out_on;
        ack_r <= {ack_r[1:0], cont_close};
        if (!aresetn) begin
            run_r <= 1'b0;
        end else if (oe_r && !out_on) begin
            run_r <= 1'b0;
        end else if (go) begin
            run_r <= 1'b1;
        end
    end
    assign dir_fwd = run_r;
    assign dir_rev = 1'b0;
    assign hw_block_n = run_r;
    // confirm follows the contactor after three cycles, drops with it
    assign mf_in = {1'b0, spd[1], ack_r[2] & cont_close, 1'b0, spd[0]};
endmodule

// >>> dv/tb.sv
/* tb: self-checking bench for hbs_top.
   assumes timers programmed to zero so a ride is short. */
`timescale 1ns/1ps
module tb
    import hbs_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, dir_fwd, dir_rev, hw_block_n, output_enable, zero_hold, go = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp, spd = 2'b00;
    logic [4:0] mf_in;
    logic [2:0] mf_out;
    logic [15:0] speed_out;
    int miscompares = 0, check_count = 0, cyc = 0, i, hold_cyc = 0, n0;
    localparam logic [15:0] TDEF [6] = '{START_INJ_RST, STOP_INJ_RST, BRAKE_OPEN_RST,
        BRAKE_CLOSE_RST, RUN_DELAY_RST, CONT_OPEN_RST};
    always #5 aclk = ~aclk;
    hbs_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .dir_fwd(dir_fwd), .dir_rev(dir_rev),
        .hw_block_n(hw_block_n), .mf_in(mf_in), .mf_out(mf_out),
        .output_enable(output_enable), .zero_hold(zero_hold), .speed_out(speed_out));
    hbs_ctrl_model u_ctrl (.aclk(aclk), .aresetn(aresetn), .go(go), .spd(spd),
        .cont_close(mf_out[1]), .out_on(output_enable), .dir_fwd(dir_fwd), .dir_rev(dir_rev),
        .hw_block_n(hw_block_n), .mf_in(mf_in));
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (zero_hold === 1'b1) hold_cyc <= hold_cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            test_done;
        end
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            axi_rd(8'(4 * k), rd, resp);
            chk({rd, resp}, {16'h0000, TDEF[k], RESP_OKAY});
            axi_wr(8'(4 * k), 32'h0, resp);
        end
        axi_rd(REG_IN_SEL, rd, resp);
        chk({rd, resp}, {32'h53525150, RESP_OKAY});
        axi_rd(REG_OUT_SEL, rd, resp);
        chk({rd, resp}, {32'h00002928, RESP_OKAY});
        axi_rd(8'h3C, rd, resp);
        chk({rd, resp}, {32'h0, RESP_SLVERR});
        axi_wr(REG_STATUS, 32'hFFFFFFFF, resp);
        chk({32'h0, resp}, {32'h0, RESP_SLVERR});
        axi_wr(REG_SPEED, 32'h00100040, resp);
        axi_wr(REG_IN_SEL, 32'h53565150, resp);
        chk({32'h0, resp}, {32'h0, RESP_OKAY});
        for (int k = 0; k < 2; k++) begin
            axi_wr(REG_ANA_SEL, (k == 0) ? 32'h00000001 : 32'h00000E00, resp);
            spd <= 2'b01;
            go <= 1'b1;
            @(posedge aclk);
            go <= 1'b0;
            repeat (40) @(posedge aclk);
            chk({31'h0, output_enable, mf_out[1:0]}, 34'h0);
        end
        spd <= 2'b00;
        axi_wr(REG_ANA_SEL, 32'h0, resp);
        repeat (40) @(posedge aclk);
        chk({31'h0, output_enable, mf_out[1:0]}, 34'h0);
        spd <= 2'b01;
        for (i = 0; i < 100 && mf_out[1] !== 1'b1; i++) @(posedge aclk);
        chk({33'h0, mf_out[1]}, 34'h1);
        for (i = 0; i < 500 && speed_out !== 16'h0040; i++) @(posedge aclk);
        chk({14'h0, output_enable, mf_out, speed_out}, {14'h0, 4'hB, 16'h0040});
        n0 = hold_cyc;
        chk({33'h0, n0 != 0}, 34'h1);
        spd <= 2'b10;
        for (i = 0; i < 200 && speed_out !== 16'h0010; i++) @(posedge aclk);
        chk({18'h0, speed_out}, 34'h10);
        spd <= 2'b00;
        for (i = 0; i < 500 && mf_out !== 3'b000; i++) @(posedge aclk);
        chk({14'h0, output_enable, mf_out, speed_out}, 34'h0);
        chk({33'h0, hold_cyc > n0}, 34'h1);
        // second ride without a confirm input: run delay only, then leveling straight away
        axi_wr(REG_IN_SEL, IN_SEL_RST[31:0], resp);
        spd <= 2'b10;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        for (i = 0; i < 100 && mf_out[1] !== 1'b1; i++) @(posedge aclk);
        repeat (2) @(posedge aclk);
        chk({32'h0, zero_hold, output_enable}, 34'h3);
        spd <= 2'b00;
        for (i = 0; i < 500 && mf_out !== 3'b000; i++) @(posedge aclk);
        chk({14'h0, output_enable, mf_out, speed_out}, 34'h0);
        test_done;
    end
endmodule
